// *** design/gpp_consts.svh ***
// register offsets, reset values and field sizes of the gpio port
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH

`define GPP_PORT_PINS 32
`define GPP_ADDR_W 8

`define GPP_OFF_FUNC_SEL 8'h00
`define GPP_OFF_OUT_DATA 8'h04
`define GPP_OFF_OUT_EN 8'h08
`define GPP_OFF_IN_DATA 8'h0c
`define GPP_OFF_PULL_EN 8'h10
`define GPP_OFF_PULL_UP 8'h14
`define GPP_OFF_DRIVE_HI 8'h18
`define GPP_OFF_INT_EN 8'h1c
`define GPP_OFF_INT_EDGE 8'h20
`define GPP_OFF_INT_POL 8'h24
`define GPP_OFF_INT_FLAG 8'h28
`define GPP_OFF_WAKE_EN 8'h2c
`define GPP_OFF_WAKE_RISE 8'h30
`define GPP_OFF_WAKE_FLAG 8'h34
`define GPP_OFF_IN_EN 8'h38

`define GPP_RST_ZERO 32'h0000_0000
`define GPP_RST_IN_EN 32'hffff_ffff

`endif

// *** design/gpp_pkg.sv ***
// types shared by the gpio port and its users
package gpp_pkg;

  // drive controls for one port of pads, one bit per pin
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
    logic [31:0] pull_up;
    logic [31:0] pull_dn;
    logic [31:0] drive_hi;
  } gpp_pad_s;

  // signals a peripheral hands to its pins
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } gpp_periph_s;

  typedef logic [7:0] gpp_addr_t;

endpackage

// *** design/gpp_port.sv ***
// one 32-pin gpio port with apb registers, pin interrupts and wake-up
`include "gpp_consts.svh"

module gpp_port #(
  parameter int NPINS = `GPP_PORT_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire gpp_pkg::gpp_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] pin_in,
  output gpp_pkg::gpp_pad_s pad,
  input wire gpp_pkg::gpp_periph_s periph,
  output logic [31:0] periph_in,
  output logic irq,
  output logic wake_req
);
  import gpp_pkg::*;

  // refuse port widths the 32-bit registers cannot hold
  if (NPINS < 1 || NPINS > `GPP_PORT_PINS) begin : g_bad_npins
    $error("gpp_port: NPINS must be 1 to 32");
  end

  // pins beyond NPINS are absent; their bits stay zero everywhere
  localparam logic [31:0] PIN_MASK = 32'hffff_ffff >> (`GPP_PORT_PINS - NPINS);

  // configuration and status registers, one bit per pin
  logic [31:0] func_sel_r;
  logic [31:0] out_data_r;
  logic [31:0] out_en_r;
  logic [31:0] in_en_r;
  logic [31:0] pull_en_r;
  logic [31:0] pull_up_r;
  logic [31:0] drive_hi_r;
  logic [31:0] int_en_r;
  logic [31:0] int_edge_r;
  logic [31:0] int_pol_r;
  logic [31:0] int_flag_r;
  logic [31:0] wake_en_r;
  logic [31:0] wake_rise_r;
  logic [31:0] wake_flag_r;
  logic [31:0] pin_prev_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // true when the bus address selects the given register
  function automatic logic hit(input gpp_addr_t a, input gpp_addr_t off);
    return a == off;
  endfunction

  // strobe-merged write value for a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic setup_ph, wr_acc;
  logic [31:0] wmask;
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  // byte strobes widened to a bit mask, used for write-one-to-clear registers
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // true when the offset names one of the port's registers; anything else answers an error
  function automatic logic known_off(input gpp_addr_t a);
    logic k;
    k = 1'b0;
    unique case (a)
      `GPP_OFF_FUNC_SEL,
      `GPP_OFF_OUT_DATA,
      `GPP_OFF_OUT_EN,
      `GPP_OFF_IN_DATA,
      `GPP_OFF_PULL_EN,
      `GPP_OFF_PULL_UP,
      `GPP_OFF_DRIVE_HI,
      `GPP_OFF_INT_EN,
      `GPP_OFF_INT_EDGE,
      `GPP_OFF_INT_POL,
      `GPP_OFF_INT_FLAG,
      `GPP_OFF_WAKE_EN,
      `GPP_OFF_WAKE_RISE,
      `GPP_OFF_WAKE_FLAG,
      `GPP_OFF_IN_EN: k = 1'b1;
      default: k = 1'b0;
    endcase
    return k;
  endfunction

  logic mapped;
  assign mapped = known_off(paddr);

  // every access completes with no wait state: read data is captured in setup
  assign pready = psel & penable;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  // function select, rewritable at any time; the pad mux follows it the very next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_sel_r <= `GPP_RST_ZERO;
    end else if (wr_acc) begin
      if (hit(paddr, `GPP_OFF_FUNC_SEL)) begin
        func_sel_r <= merge(func_sel_r, pwdata, pstrb) & PIN_MASK;
      end
    end
  end

  // firmware output level, output enable and input buffer enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_data_r <= `GPP_RST_ZERO;
      out_en_r <= `GPP_RST_ZERO;
      in_en_r <= `GPP_RST_IN_EN & PIN_MASK;
    end else if (wr_acc) begin
      if (hit(paddr, `GPP_OFF_OUT_DATA)) begin
        out_data_r <= merge(out_data_r, pwdata, pstrb) & PIN_MASK;
      end
      if (hit(paddr, `GPP_OFF_OUT_EN)) begin
        out_en_r <= merge(out_en_r, pwdata, pstrb) & PIN_MASK;
      end
      if (hit(paddr, `GPP_OFF_IN_EN)) begin
        in_en_r <= merge(in_en_r, pwdata, pstrb) & PIN_MASK;
      end
    end
  end

  // pad electrical settings: pull choice and drive strength
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_en_r <= `GPP_RST_ZERO;
      pull_up_r <= `GPP_RST_ZERO;
      drive_hi_r <= `GPP_RST_ZERO;
    end else if (wr_acc) begin
      if (hit(paddr, `GPP_OFF_PULL_EN)) begin
        pull_en_r <= merge(pull_en_r, pwdata, pstrb) & PIN_MASK;
      end
      if (hit(paddr, `GPP_OFF_PULL_UP)) begin
        pull_up_r <= merge(pull_up_r, pwdata, pstrb) & PIN_MASK;
      end
      if (hit(paddr, `GPP_OFF_DRIVE_HI)) begin
        drive_hi_r <= merge(drive_hi_r, pwdata, pstrb) & PIN_MASK;
      end
    end
  end

  // pin interrupt mask, detection mode and polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_r <= `GPP_RST_ZERO;
      int_edge_r <= `GPP_RST_ZERO;
      int_pol_r <= `GPP_RST_ZERO;
    end else if (wr_acc) begin
      if (hit(paddr, `GPP_OFF_INT_EN)) begin
        int_en_r <= merge(int_en_r, pwdata, pstrb) & PIN_MASK;
      end
      if (hit(paddr, `GPP_OFF_INT_EDGE)) begin
        int_edge_r <= merge(int_edge_r, pwdata, pstrb) & PIN_MASK;
      end
      if (hit(paddr, `GPP_OFF_INT_POL)) begin
        int_pol_r <= merge(int_pol_r, pwdata, pstrb) & PIN_MASK;
      end
    end
  end

  // wake-up enable and edge choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en_r <= `GPP_RST_ZERO;
      wake_rise_r <= `GPP_RST_ZERO;
    end else if (wr_acc) begin
      if (hit(paddr, `GPP_OFF_WAKE_EN)) begin
        wake_en_r <= merge(wake_en_r, pwdata, pstrb) & PIN_MASK;
      end
      if (hit(paddr, `GPP_OFF_WAKE_RISE)) begin
        wake_rise_r <= merge(wake_rise_r, pwdata, pstrb) & PIN_MASK;
      end
    end
  end

  // pad drive; each pin's lane is built in the per-pin loop further down
  logic [31:0] oe_mux, out_mux, in_live, pull_up_mux, pull_dn_mux;
  logic [31:0] rise, fall, int_ev, wake_ev;
  assign pad.out = out_mux;
  assign pad.oe = oe_mux;
  assign pad.pull_up = pull_up_mux;
  assign pad.pull_dn = pull_dn_mux;
  assign pad.drive_hi = drive_hi_r;
  assign periph_in = pin_in & func_sel_r & PIN_MASK;

  // previous pin sample for edge detection; inputs are already synchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_r <= `GPP_RST_ZERO;
    end else begin
      pin_prev_r <= pin_in & PIN_MASK;
    end
  end

  // per-pin mux, pull gating and event detection; pins past NPINS are tied off
  for (genvar i = 0; i < 32; i++) begin : g_pin
    if (i < NPINS) begin : g_live
      logic fw, oe_b, in_b, lvl_b, edge_b;
      assign fw = ~func_sel_r[i];
      // a peripheral pin ignores the firmware output and direction
      assign oe_b = fw ? out_en_r[i] : periph.oe[i];
      assign oe_mux[i] = oe_b;
      assign out_mux[i] = fw ? out_data_r[i] : periph.out[i];
      // input buffer always on for peripheral pins so they can receive
      assign in_b = in_en_r[i] | func_sel_r[i];
      assign in_live[i] = pin_in[i] & in_b;
      // a pull needs an undriven pin with its input on, so it never fights a driver
      assign pull_up_mux[i] = pull_en_r[i] & pull_up_r[i] & ~oe_b & in_b;
      assign pull_dn_mux[i] = pull_en_r[i] & ~pull_up_r[i] & ~oe_b & in_b;
      assign rise[i] = pin_in[i] & ~pin_prev_r[i];
      assign fall[i] = ~pin_in[i] & pin_prev_r[i];
      // polarity bit: 1 selects high level or rising edge
      assign lvl_b = ~(pin_in[i] ^ int_pol_r[i]);
      assign edge_b = int_pol_r[i] ? rise[i] : fall[i];
      // only input pins under firmware control raise pin interrupts
      assign int_ev[i] = (int_edge_r[i] ? edge_b : lvl_b) & in_en_r[i] & fw;
      assign wake_ev[i] = (wake_rise_r[i] ? rise[i] : fall[i]) & wake_en_r[i];
    end else begin : g_absent
      // a pin the port does not have drives nothing and reports nothing
      assign oe_mux[i] = 1'b0;
      assign out_mux[i] = 1'b0;
      assign in_live[i] = 1'b0;
      assign pull_up_mux[i] = 1'b0;
      assign pull_dn_mux[i] = 1'b0;
      assign rise[i] = 1'b0;
      assign fall[i] = 1'b0;
      assign int_ev[i] = 1'b0;
      assign wake_ev[i] = 1'b0;
    end
  end

  logic [31:0] clr_int, clr_wake;
  assign clr_int = (wr_acc && hit(paddr, `GPP_OFF_INT_FLAG)) ? (pwdata & wmask) : 32'h0000_0000;
  assign clr_wake = (wr_acc && hit(paddr, `GPP_OFF_WAKE_FLAG)) ? (pwdata & wmask) :
                    32'h0000_0000;

  // sticky pending flags; a new event beats a same-cycle write-one-to-clear.
  // a level interrupt re-pends each cycle its level holds, so clear after the source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_flag_r <= `GPP_RST_ZERO;
    end else begin
      int_flag_r <= ((int_flag_r & ~clr_int) | int_ev) & PIN_MASK;
    end
  end

  // wake flags record edges only on pins with wake enabled; every flag reaches the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_flag_r <= `GPP_RST_ZERO;
    end else begin
      wake_flag_r <= ((wake_flag_r & ~clr_wake) | wake_ev) & PIN_MASK;
    end
  end

  // one port-wide interrupt line; it looks ahead at the flag's next value to save a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_flag_r & ~clr_int) | int_ev) & int_en_r);
    end
  end

  // one wake request line, high while any wake flag stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= |((wake_flag_r & ~clr_wake) | wake_ev);
    end
  end

  // read data captured during setup; unmapped addresses read zero with an error
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      hit(paddr, `GPP_OFF_FUNC_SEL): rd_mux = func_sel_r;
      hit(paddr, `GPP_OFF_OUT_DATA): rd_mux = out_data_r;
      hit(paddr, `GPP_OFF_OUT_EN): rd_mux = out_en_r;
      hit(paddr, `GPP_OFF_IN_DATA): rd_mux = in_live;
      hit(paddr, `GPP_OFF_PULL_EN): rd_mux = pull_en_r;
      hit(paddr, `GPP_OFF_PULL_UP): rd_mux = pull_up_r;
      hit(paddr, `GPP_OFF_DRIVE_HI): rd_mux = drive_hi_r;
      hit(paddr, `GPP_OFF_INT_EN): rd_mux = int_en_r;
      hit(paddr, `GPP_OFF_INT_EDGE): rd_mux = int_edge_r;
      hit(paddr, `GPP_OFF_INT_POL): rd_mux = int_pol_r;
      hit(paddr, `GPP_OFF_INT_FLAG): rd_mux = int_flag_r;
      hit(paddr, `GPP_OFF_WAKE_EN): rd_mux = wake_en_r;
      hit(paddr, `GPP_OFF_WAKE_RISE): rd_mux = wake_rise_r;
      hit(paddr, `GPP_OFF_WAKE_FLAG): rd_mux = wake_flag_r;
      hit(paddr, `GPP_OFF_IN_EN): rd_mux = in_en_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data taken at the setup edge, so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // error flag for an unmapped offset, shown only in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      pslverr_r <= ~mapped;
    end
  end

endmodule // gpp_port

// *** sim/gpp_asserts.sv ***
// concurrent checks on the gpio port boundary
module gpp_asserts #(
  parameter int NPINS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] pin_in,
  input wire gpp_pkg::gpp_pad_s pad,
  input wire gpp_pkg::gpp_periph_s periph,
  input wire logic [31:0] periph_in,
  input wire logic irq,
  input wire logic wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpp_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  // settings only change and flags only clear at a write access edge; sticky checks skip two cycles around it
  assign wr_acc = psel && penable && pwrite;
  a_ready_access: assert property (pready == (psel && penable))
    else $error("pready outside access phase");
  a_err_in_access: assert property (pslverr |-> pready)
    else $error("pslverr outside access phase");
  a_pull_input: assert property ((((pad.pull_up | pad.pull_dn) & pad.oe) |
    (pad.pull_up & pad.pull_dn)) == 32'h0) else $error("pull on driven pin");
  a_periph_owns: assert property (((pad.oe ^ periph.oe) & periph_in) == 32'h0)
    else $error("peripheral pin not driven by peripheral");
  a_periph_in_pin: assert property ((periph_in & ~pin_in) == 32'h0)
    else $error("peripheral input without pin level");
  a_drive_holds: assert property (!wr_acc |=> $stable(pad.drive_hi))
    else $error("drive strength changed without write");
  a_irq_sticky: assert property (irq && !wr_acc && !$past(wr_acc) |=> irq)
    else $error("irq dropped without write");
  a_wake_sticky: assert property (wake_req && !wr_acc && !$past(wr_acc) |=> wake_req)
    else $error("wake dropped without write");
  a_reset_quiet: assert property ($rose(presetn) |-> !irq && !wake_req)
    else $error("request high out of reset");
endmodule // gpp_asserts

bind gpp_port gpp_asserts #(.NPINS(NPINS)) u_asserts (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .pslverr, .pin_in, .pad, .periph, .periph_in, .irq, .wake_req);

// *** sim/gpp_board.sv ***
// board side of the pins: outside drivers, pulls and floating lines
module gpp_board (
  input wire logic pclk,
  input wire gpp_pkg::gpp_pad_s pad,
  input wire logic [31:0] ext_oe,
  input wire logic [31:0] ext_val,
  output logic [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpp_pkg::*;
  // pad sampled per clock; a floating pin flips every cycle so no level is implied
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 32; i++) begin
      if (pad.oe[i]) pin_in[i] <= pad.out[i];
      else if (ext_oe[i]) pin_in[i] <= ext_val[i];
      else if (pad.pull_up[i] | pad.pull_dn[i]) pin_in[i] <= pad.pull_up[i];
      else pin_in[i] <= (pin_in[i] === 1'b1) ? 1'b0 : 1'b1;
    end
  end
endmodule // gpp_board

// *** sim/tb.sv ***
// self-checking bench for the gpio port
`include "gpp_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpp_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  gpp_addr_t paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, ext_oe = 32'hffff_fcff, ext_val = 32'h0;
  logic [31:0] prdata, pin_in, periph_in, rdat;
  logic pready, pslverr, irq, wake_req, rerr;
  gpp_pad_s pad;
  gpp_periph_s periph = 64'h0;
  int bad_count = 0;
  int samples_checked = 0;
  always #5 pclk = ~pclk;
  gpp_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .prdata, .pready, .pslverr, .pin_in, .pad, .periph, .periph_in, .irq, .wake_req);
  gpp_board u_board (.pclk, .pad, .ext_oe, .ext_val, .pin_in);
  // one apb transfer; the request stands until pready is seen at an edge
  task automatic xfer(input logic w, input gpp_addr_t a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic flag(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic rd(input gpp_addr_t a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
    flag(rerr, 1'b0);
  endtask
  task automatic wr(input gpp_addr_t a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // outputs are looked at 1 ns after an edge, once that edge's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a hang is cut far beyond the 130 or so cycles the tests need
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
  initial begin
    tick(4);
    presetn <= 1'b1;
    rd(`GPP_OFF_IN_EN, `GPP_RST_IN_EN);
    rd(`GPP_OFF_FUNC_SEL, `GPP_RST_ZERO);
    rd(`GPP_OFF_DRIVE_HI, `GPP_RST_ZERO);
    xfer(1'b0, 8'h3c, 32'h0);
    chk(rdat, 32'h0);
    flag(rerr, 1'b1);
    $display("test reset done");
    wr(`GPP_OFF_OUT_EN, 32'h0000_00ff);
    wr(`GPP_OFF_OUT_DATA, 32'h0000_00a5);
    wr(`GPP_OFF_PULL_EN, 32'h0000_0300);
    wr(`GPP_OFF_PULL_UP, 32'h0000_0100);
    tick(2);
    chk(pad.pull_up, 32'h0000_0100);
    chk(pad.pull_dn, 32'h0000_0200);
    rd(`GPP_OFF_IN_DATA, 32'h0000_01a5);
    wr(`GPP_OFF_IN_EN, 32'hffff_fffe);
    wr(`GPP_OFF_OUT_EN, 32'h0000_01ff);
    tick(2);
    chk(pad.pull_up, 32'h0);
    rd(`GPP_OFF_IN_DATA, 32'h0000_00a4);
    wr(`GPP_OFF_DRIVE_HI, 32'h8000_0001);
    tick(1);
    chk(pad.drive_hi, 32'h8000_0001);
    wr(`GPP_OFF_IN_EN, 32'hffff_ffff);
    $display("test pins done");
    periph <= {32'h0000_0003, 32'h0000_000f};
    wr(`GPP_OFF_FUNC_SEL, 32'h0000_00ff);
    tick(2);
    chk(pad.oe, 32'h0000_010f);
    chk(pad.out, 32'h0000_0003);
    chk(periph_in, 32'h0000_0003);
    wr(`GPP_OFF_FUNC_SEL, 32'h0);
    tick(1);
    chk(pad.oe, 32'h0000_01ff);
    $display("test function done");
    wr(`GPP_OFF_INT_EDGE, 32'h0000_1000);
    wr(`GPP_OFF_INT_POL, 32'h0000_3000);
    wr(`GPP_OFF_INT_FLAG, 32'hffff_ffff);
    wr(`GPP_OFF_INT_EN, 32'h0000_3000);
    tick(1);
    flag(irq, 1'b0);
    ext_val <= 32'h0000_1000;
    tick(3);
    flag(irq, 1'b1);
    xfer(1'b0, `GPP_OFF_INT_FLAG, 32'h0);
    chk(rdat & 32'h0000_3000, 32'h0000_1000);
    wr(`GPP_OFF_INT_EN, 32'h0000_2000);
    tick(1);
    flag(irq, 1'b0);
    wr(`GPP_OFF_INT_EN, 32'h0000_3000);
    tick(1);
    flag(irq, 1'b1);
    wr(`GPP_OFF_INT_FLAG, 32'h0000_1000);
    tick(1);
    flag(irq, 1'b0);
    ext_val <= 32'h0000_3000;
    tick(3);
    flag(irq, 1'b1);
    wr(`GPP_OFF_INT_FLAG, 32'h0000_2000);
    tick(1);
    flag(irq, 1'b1);
    wr(`GPP_OFF_FUNC_SEL, 32'h0000_2000);
    wr(`GPP_OFF_INT_FLAG, 32'h0000_2000);
    tick(1);
    flag(irq, 1'b0);
    wr(`GPP_OFF_FUNC_SEL, 32'h0);
    wr(`GPP_OFF_INT_EN, 32'h0);
    $display("test interrupt done");
    ext_val <= 32'h0000_7000;
    wr(`GPP_OFF_WAKE_EN, 32'h0000_4000);
    wr(`GPP_OFF_WAKE_FLAG, 32'hffff_ffff);
    tick(1);
    flag(wake_req, 1'b0);
    ext_val <= 32'h0000_3000;
    tick(3);
    flag(wake_req, 1'b1);
    wr(`GPP_OFF_WAKE_RISE, 32'h0000_4000);
    wr(`GPP_OFF_WAKE_FLAG, 32'h0000_4000);
    tick(1);
    flag(wake_req, 1'b0);
    ext_val <= 32'h0000_7000;
    tick(3);
    flag(wake_req, 1'b1);
    $display("test wake done");
    give_verdict();
  end
endmodule // tb
